// ==== logic/touch_adc_device.sv ====
// How it works
// [RL1] Conversion spans three eight-clock byte transfers.
// [RL2] Host sends command in first eight clocks.
// [RL3] Enough command bits start acquisition, switches on.
// [RL4] Three clocks later hold and start conversion.
// [RL5] Twelve conversion clocks, thirteenth delivers last bit.
// [RL6] Trailing pad clocks keep output low.
// [RL7] Differential reference keeps switches on converting.
// [RL8] Ignore input until first high start bit.
// [RL9] Command bits: start, channel, mode, reference, power.
// [RL10] Channel and reference bits steer mux, switches.
// [RL11] Mode bit picks twelve or eight bits.
// [RL12] Reference high single-ended, low differential.
// [RL13] Next command after fifteen or eleven clocks.
// [RL14] Power-down 00 irq and switch on; 01 off.
// [RL15] Code 11 stays powered; 10 reserved.
// [RL16] Wake instantly on new conversion.
// [RL17] Next command may overlap result transfer.
// [RL18] Host finishes each conversion within 1.6 ms.
// [RL19] Stay powered while clock pauses mid-conversion.
// [RL20] Sample on rising edges, update on falling.
// [RL21] Outputs driven only while select is low.
// [RL22] Eight-bit conversion ends four clocks earlier.
// [RL23] Result is straight binary.
// [RL24] Result shifts out MSB first after command.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`include "touch_adc_regs.svh"

module touch_adc_device
    import touch_adc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Serial link
    touch_link_if.dev_end    link,
    // Converter core and panel
    input  wire logic [11:0] sample_value,
    input  wire logic        pen_touched,
    // Configuration and state seen by the analog side
    output logic      [2:0]  channel_select_bits,
    output logic             resolution_8bit,
    output logic             reference_select,
    output logic      [1:0]  power_down_select,
    output logic             switches_on,
    output logic             x_switches,
    output logic             y_switches,
    output logic             aux_select,
    output logic             acquiring,
    output logic             sample_hold,
    output logic             converting,
    output logic             low_power,
    output logic             lower_right_switch,
    output logic             touch_irq_out
);

    dev_state_t s;
    dev_state_t next_s;

    logic       active;
    logic       rise;
    logic       fall;
    logic [3:0] cnt_inc;
    logic [6:0] new_sr;
    logic [3:0] k;
    logic [3:0] res_len;
    logic       start_ok;

    function automatic logic chan_is(input logic [2:0] chan, input logic [2:0] code);
        chan_is = (chan == code);
    endfunction

    // Reserved code 10 is treated as always on, the safe reading of an unused code.
    function automatic logic pd_sleeps(input logic [1:0] pd);
        pd_sleeps = (pd != `PD_ALWAYS_ON) & (pd != `PD_RESERVED);
    endfunction

    // Edges are found on the second synchroniser stage only.
    assign active   = ~s.cs_sync[1];
    assign rise     = s.sclk_sync[1] & ~s.sclk_last;
    assign fall     = ~s.sclk_sync[1] & s.sclk_last;
    assign cnt_inc  = s.cmd_cnt + 4'h1;
    assign new_sr   = {s.cmd_sr[5:0], s.din_sync[1]};
    assign k        = s.fall_cnt + 4'h1;
    assign res_len  = s.mode8 ? `RES8_LEN : `RES12_LEN;
    // The next start bit is looked for while the old result is still going out.
    assign start_ok = ~s.conv_active
                    | (s.fall_cnt >= (s.mode8 ? `NEXT_START_8 : `NEXT_START_12)); // [RL13] [RL17]

    always_comb begin
        next_s           = s;
        next_s.sclk_sync = {s.sclk_sync[0], link.shift_clock};
        next_s.cs_sync   = {s.cs_sync[0], link.cs_n};
        next_s.din_sync  = {s.din_sync[0], link.din};
        next_s.pen_sync  = {s.pen_sync[0], pen_touched};
        next_s.sclk_last = s.sclk_sync[1];
        next_s.dout_oe_n = s.cs_sync[1]; // [RL21]
        next_s.busy_oe_n = s.cs_sync[1]; // [RL21]

        // Raising select abandons a half-received command byte and any running conversion.
        // Otherwise a cut frame would leave the panel powered and block every later start bit.
        // A cut during acquisition applies the power code of the previous command.
        if (!active) begin
            next_s.cmd_cnt = 4'h0;
            if (s.conv_active || s.acquiring) begin
                next_s.conv_active = 1'b0;
                next_s.acquiring   = 1'b0;
                next_s.hold        = 1'b0;
                next_s.switches_on = 1'b0;
                next_s.busy        = 1'b0;
                next_s.dout        = 1'b0;
                next_s.low_power   = pd_sleeps(s.pd); // [RL14]
            end
        end

        if (active && rise) begin // [RL20]
            if (s.cmd_cnt == 4'h0) begin
                if (s.din_sync[1] && start_ok) begin // [RL8]
                    next_s.cmd_cnt   = 4'h1;
                    next_s.low_power = 1'b0; // [RL16]
                end
            end else begin
                next_s.cmd_sr  = new_sr; // [RL2]
                next_s.cmd_cnt = cnt_inc;
                if (cnt_inc == `ACQ_AFTER_BITS) begin
                    // Channel bits are complete here, so the panel can start settling.
                    next_s.chan        = new_sr[3:1]; // [RL3] [RL10]
                    next_s.acquiring   = 1'b1; // [RL3]
                    next_s.hold        = 1'b0;
                    next_s.switches_on = 1'b1; // [RL3]
                end
                if (cnt_inc == `CMD_BITS) begin
                    next_s.cmd_cnt     = 4'h0;
                    next_s.chan        = new_sr[`CMD_CHAN_MSB:`CMD_CHAN_LSB]; // [RL9] [RL10]
                    next_s.mode8       = new_sr[`CMD_MODE_BIT]; // [RL9] [RL11]
                    next_s.ref_se      = new_sr[`CMD_REF_BIT]; // [RL9] [RL12]
                    next_s.pd          = new_sr[`CMD_PD_MSB:`CMD_PD_LSB]; // [RL9]
                    next_s.acquiring   = 1'b0;
                    next_s.hold        = 1'b1; // [RL4]
                    next_s.conv_active = 1'b1; // [RL4]
                    next_s.fall_cnt    = 4'h0;
                    // Differential reference needs the panel powered through conversion.
                    next_s.switches_on = ~new_sr[`CMD_REF_BIT]; // [RL4] [RL7] [RL12]
                    if (new_sr[`CMD_MODE_BIT]) begin
                        next_s.result = {sample_value[11:4], 4'h0}; // [RL11] [RL23]
                    end else begin
                        next_s.result = sample_value; // [RL23]
                    end
                end
            end
        end

        if (active && fall && s.conv_active) begin // [RL20]
            next_s.fall_cnt = k;
            if (k == 4'h1) begin
                next_s.busy = 1'b1;
                next_s.dout = 1'b0;
            end else if (k <= res_len + 4'h1) begin // [RL5] [RL22]
                next_s.busy   = 1'b0;
                next_s.dout   = s.result[11]; // [RL24]
                next_s.result = {s.result[10:0], 1'b0}; // [RL24]
            end else begin
                next_s.busy        = 1'b0;
                next_s.dout        = 1'b0; // [RL6]
                next_s.conv_active = 1'b0;
                // An overlapped command already owns the switches and power state.
                if (s.cmd_cnt == 4'h0 && next_s.cmd_cnt == 4'h0) begin
                    next_s.hold        = 1'b0;
                    next_s.switches_on = 1'b0;
                    next_s.low_power   = pd_sleeps(s.pd); // [RL14] [RL15] [RL19]
                end
            end
        end

        next_s.x_sw    = next_s.switches_on & chan_is(next_s.chan, `CHAN_X_DRIVE); // [RL10]
        next_s.y_sw    = next_s.switches_on & chan_is(next_s.chan, `CHAN_Y_DRIVE); // [RL10]
        next_s.aux_sel = next_s.acquiring & chan_is(next_s.chan, `CHAN_AUX); // [RL10]
        next_s.lr_sw   = next_s.low_power & (next_s.pd == `PD_AUTO_IRQ); // [RL14]
        next_s.irq     = (s.pd == `PD_AUTO_IRQ) & s.pen_sync[1]; // [RL14] [RL15]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s           <= '0;
            s.cs_sync   <= 2'h3;
            s.dout_oe_n <= 1'b1;
            s.busy_oe_n <= 1'b1;
            s.pd        <= `RST_PD;
            s.low_power <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.dout           = s.dout;
    assign link.dout_oe_n      = s.dout_oe_n;
    assign link.busy           = s.busy;
    assign link.busy_oe_n      = s.busy_oe_n;
    assign channel_select_bits = s.chan;
    assign resolution_8bit     = s.mode8;
    assign reference_select    = s.ref_se;
    assign power_down_select   = s.pd;
    assign switches_on         = s.switches_on;
    assign x_switches          = s.x_sw;
    assign y_switches          = s.y_sw;
    assign aux_select          = s.aux_sel;
    assign acquiring           = s.acquiring;
    assign sample_hold         = s.hold;
    assign converting          = s.conv_active;
    assign low_power           = s.low_power;
    assign lower_right_switch  = s.lr_sw;
    assign touch_irq_out       = s.irq;

endmodule // touch_adc_device

// ==== logic/touch_adc_host.sv ====
`include "touch_adc_regs.svh"

module touch_adc_host
    import touch_adc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial link
    touch_link_if.host_end   link
);

    host_state_t h;
    host_state_t next_h;

    logic [15:0] rx_new;
    logic        half_end;

    function automatic logic [31:0] read_mux(input host_state_t st, input logic [3:0] addr);
        unique case (addr)
            `REG_CMD_OFS:    read_mux = {24'h0, st.cmd};
            `REG_STATUS_OFS: read_mux = {29'h0, st.busy_sync[1], st.done,
                                         st.phase == HOST_SHIFT};
            `REG_RESULT_OFS: read_mux = {20'h0, st.result};
            default:         read_mux = 32'h0;
        endcase
    endfunction

    assign rx_new   = {h.rx[14:0], h.dout_sync[1]};
    assign half_end = (h.half_cnt == 3'(`HALF_CYCLES - 1));

    always_comb begin
        next_h           = h;
        next_h.dout_sync = {h.dout_sync[0], link.dout_line};
        next_h.busy_sync = {h.busy_sync[0], link.busy_line};

        // Only whole-word accesses are issued, so the transfer size is not decoded.
        next_h.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_h.wr_pend = hwrite;
            next_h.wr_addr = haddr[3:0];
            if (!hwrite) begin
                next_h.hrdata = read_mux(h, haddr[3:0]);
            end
        end

        // A command written while a transfer runs is dropped.
        if (h.wr_pend && h.wr_addr == `REG_CMD_OFS && h.phase == HOST_IDLE) begin
            next_h.cmd      = hwdata[7:0];
            next_h.tx       = hwdata[7:0];
            next_h.din      = hwdata[`CMD_START_BIT]; // [RL2]
            next_h.cs_n     = 1'b0;
            next_h.sclk     = 1'b0;
            next_h.half_cnt = 3'h0;
            next_h.clk_no   = 5'h0;
            next_h.done     = 1'b0;
            next_h.phase    = HOST_SHIFT;
        end

        // Clocking runs without pauses, so a conversion ends well inside the droop limit.
        if (h.phase == HOST_SHIFT) begin // [RL18]
            next_h.half_cnt = half_end ? 3'h0 : h.half_cnt + 3'h1;
            if (half_end && !h.sclk) begin
                next_h.sclk   = 1'b1;
                next_h.clk_no = h.clk_no + 5'h1;
            end else if (half_end) begin
                // Result bits are taken late in the high phase, after the device's falling update.
                if (h.clk_no > `DATA_FIRST_CLOCK) begin // [RL20]
                    next_h.rx = rx_new;
                end
                next_h.sclk = 1'b0;
                next_h.din  = h.tx[6]; // [RL20]
                next_h.tx   = {h.tx[6:0], 1'b0};
                if (h.clk_no == `XFER_CLOCKS) begin // [RL1]
                    next_h.cs_n  = 1'b1; // [RL21]
                    next_h.phase = HOST_IDLE;
                    next_h.done  = 1'b1;
                    if (h.cmd[`CMD_MODE_BIT]) begin
                        next_h.result = {4'h0, rx_new[14:7]}; // [RL11]
                    end else begin
                        next_h.result = rx_new[14:3];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            h           <= '0;
            h.phase     <= HOST_IDLE;
            h.cs_n      <= 1'b1;
            h.cmd       <= `RST_CMD;
            h.hreadyout <= 1'b1;
        end else begin
            h <= next_h;
        end
    end

    assign hrdata           = h.hrdata;
    assign hreadyout        = h.hreadyout;
    assign hresp            = h.hresp;
    assign link.cs_n        = h.cs_n;
    assign link.shift_clock = h.sclk;
    assign link.din         = h.din;

endmodule // touch_adc_host

// ==== logic/touch_adc_pkg.sv ====
package touch_adc_pkg;

    typedef enum logic {HOST_IDLE, HOST_SHIFT} host_phase_t;

    typedef struct packed {
        logic [1:0]  sclk_sync;
        logic [1:0]  cs_sync;
        logic [1:0]  din_sync;
        logic [1:0]  pen_sync;
        logic        sclk_last;
        logic [3:0]  cmd_cnt;
        logic [6:0]  cmd_sr;
        logic [2:0]  chan;
        logic        mode8;
        logic        ref_se;
        logic [1:0]  pd;
        logic        conv_active;
        logic [3:0]  fall_cnt;
        logic [11:0] result;
        logic        dout;
        logic        dout_oe_n;
        logic        busy;
        logic        busy_oe_n;
        logic        switches_on;
        logic        x_sw;
        logic        y_sw;
        logic        aux_sel;
        logic        acquiring;
        logic        hold;
        logic        low_power;
        logic        lr_sw;
        logic        irq;
    } dev_state_t;

    typedef struct packed {
        host_phase_t phase;
        logic [1:0]  dout_sync;
        logic [1:0]  busy_sync;
        logic [2:0]  half_cnt;
        logic [4:0]  clk_no;
        logic        cs_n;
        logic        sclk;
        logic        din;
        logic [7:0]  tx;
        logic [7:0]  cmd;
        logic [15:0] rx;
        logic [11:0] result;
        logic        done;
        logic        wr_pend;
        logic [3:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } host_state_t;

endpackage

// ==== logic/touch_adc_regs.svh ====
`ifndef TOUCH_ADC_REGS_SVH
`define TOUCH_ADC_REGS_SVH

// Command byte layout.
`define CMD_START_BIT    7
`define CMD_CHAN_MSB     6
`define CMD_CHAN_LSB     4
`define CMD_MODE_BIT     3
`define CMD_REF_BIT      2
`define CMD_PD_MSB       1
`define CMD_PD_LSB       0
`define CMD_BITS         4'h8
`define ACQ_AFTER_BITS   4'h5

// Channel select codes that steer the panel switches and the auxiliary input select.
`define CHAN_Y_DRIVE     3'h1
`define CHAN_X_DRIVE     3'h5
`define CHAN_AUX         3'h2

// Power-down select codes.
`define PD_AUTO_IRQ      2'h0
`define PD_ALWAYS_ON     2'h3
`define PD_RESERVED      2'h2

// Result lengths, falling-edge counts within a conversion, and host link clock counts per frame.
`define RES12_LEN        4'hc
`define RES8_LEN         4'h8
`define NEXT_START_12    4'h8
`define NEXT_START_8     4'h4
`define XFER_CLOCKS      5'h18
`define DATA_FIRST_CLOCK 5'h8

// Timing.
`define CLK_PERIOD_NS    100
`define LINK_PERIOD_NS   800
`define HALF_CYCLES      ((`LINK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Host register map and reset values.
`define REG_CMD_OFS      4'h0
`define REG_STATUS_OFS   4'h4
`define REG_RESULT_OFS   4'h8
`define RST_CMD          8'h00
`define RST_PD           2'h0

`endif

// ==== logic/touch_link_if.sv ====
interface touch_link_if;
    logic cs_n;
    logic shift_clock;
    logic din;
    logic dout;
    logic dout_oe_n;
    logic busy;
    logic busy_oe_n;
    logic dout_line;
    logic busy_line;

    // A released line reads low, standing in for a weak pull-down on the board.
    assign dout_line = dout_oe_n ? 1'b0 : dout;
    assign busy_line = busy_oe_n ? 1'b0 : busy;

    modport dev_end (input cs_n, shift_clock, din, output dout, dout_oe_n, busy, busy_oe_n);
    modport host_end (output cs_n, shift_clock, din, input dout_line, busy_line);
endinterface

// ==== tb/touch_adc_serial_control_assertions.sv ====
module touch_adc_serial_control_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link signals
    input wire logic cs_n,
    input wire logic shift_clock,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic busy,
    input wire logic busy_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [4:0] rise_cnt;
    logic       sclk_q;

    // The count is kept through the edge that raises select, so the frame length can be judged.
    always_ff @(posedge clk) begin
        sclk_q <= shift_clock;
        if (sys_rst || cs_n) begin
            rise_cnt <= 5'h00;
        end else if (shift_clock && !sclk_q) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_frame_len; $rose(cs_n) |-> rise_cnt == 5'h18; endproperty
    property p_busy_start; $rose(busy) |-> rise_cnt == 5'h08; endproperty
    property p_busy_len; $rose(busy) |-> busy [*8] ##1 !busy; endproperty
    property p_dout_edge; $changed(dout) |-> !$past(shift_clock); endproperty
    property p_busy_edge; $changed(busy) |-> !$past(shift_clock); endproperty
    property p_pad_low;
        shift_clock && $past(shift_clock) && (rise_cnt == 5'h09 || rise_cnt >= 5'h16) |-> !dout;
    endproperty
    property p_release; cs_n [*6] |-> dout_oe_n && busy_oe_n; endproperty
    property p_enable; $fell(cs_n) |-> ##[1:4] (!dout_oe_n && !busy_oe_n); endproperty

    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    a_busy_start: assert property (p_busy_start) else $error("busy rose late");
    a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
    a_dout_edge: assert property (p_dout_edge) else $error("dout moved on rise");
    a_busy_edge: assert property (p_busy_edge) else $error("busy moved on rise");
    a_pad_low: assert property (p_pad_low) else $error("pad bit not low");
    a_release: assert property (p_release) else $error("line not released");
    a_enable: assert property (p_enable) else $error("line not enabled");

    c_busy: cover property ($rose(busy));
    c_frame: cover property ($rose(cs_n));
    c_one: cover property (dout && shift_clock);
endmodule // touch_adc_serial_control_assertions

// ==== tb/touch_adc_serial_control_tb_top.sv ====
`include "touch_adc_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module touch_adc_serial_control_tb_top;
    import touch_adc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, pen_touched;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, pd_sel;
    logic [11:0] sample_value;
    logic [2:0]  chan;
    logic        res8, ref_sel, sw_on, x_sw, y_sw, aux_sel, acq, s_hold, conv, low_pwr;
    logic        lr_sw, irq, sclk_q, seen_x, seen_y, seen_aux, seen_hsw, seen_busy, seen_slp;
    logic [23:0] din_mon, dout_mon;
    int          bad_count, total_checks;

    touch_link_if u_touch_link_if ();
    touch_adc_host u_touch_adc_host (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(u_touch_link_if));
    touch_adc_device u_touch_adc_device (.clk(clk), .sys_rst(sys_rst), .link(u_touch_link_if),
        .sample_value(sample_value), .pen_touched(pen_touched), .channel_select_bits(chan),
        .resolution_8bit(res8), .reference_select(ref_sel), .power_down_select(pd_sel),
        .switches_on(sw_on), .x_switches(x_sw), .y_switches(y_sw), .aux_select(aux_sel),
        .acquiring(acq), .sample_hold(s_hold), .converting(conv), .low_power(low_pwr),
        .lower_right_switch(lr_sw), .touch_irq_out(irq));
    touch_adc_serial_control_assertions u_touch_adc_serial_control_assertions (.clk(clk),
        .sys_rst(sys_rst), .cs_n(u_touch_link_if.cs_n), .shift_clock(u_touch_link_if.shift_clock),
        .dout(u_touch_link_if.dout), .dout_oe_n(u_touch_link_if.dout_oe_n),
        .busy(u_touch_link_if.busy), .busy_oe_n(u_touch_link_if.busy_oe_n));

    always #50 clk = ~clk;

    // Wire monitor: shifts din and the resolved dout at every rising link edge.
    always @(posedge clk) begin
        sclk_q <= u_touch_link_if.shift_clock;
        if (u_touch_link_if.shift_clock && !sclk_q && !u_touch_link_if.cs_n) begin
            din_mon <= {din_mon[22:0], u_touch_link_if.din};
            dout_mon <= {dout_mon[22:0], u_touch_link_if.dout_line};
        end
        if (x_sw) seen_x = 1'b1;
        if (y_sw) seen_y = 1'b1;
        if (aux_sel) seen_aux = 1'b1;
        if (sw_on && s_hold) seen_hsw = 1'b1;
        if (u_touch_link_if.busy_line) seen_busy = 1'b1;
        if (low_pwr && conv) seen_slp = 1'b1;
    end

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= wr;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin bad_count++; give_verdict(); end
        `CHK(hresp, 1'b0)
    endtask

    // Starts a transfer, waits for done and returns RESULT; an optional second
    // write while busy must be dropped by the host.
    task automatic xfer(input logic [7:0] cmd, input logic dbl, output logic [31:0] rd);
        int n;
        {seen_x, seen_y, seen_aux, seen_hsw, seen_busy, seen_slp} = 6'h00;
        bus(1'b1, `REG_CMD_OFS, cmd, rd);
        if (dbl) bus(1'b1, `REG_CMD_OFS, 8'h00, rd);
        rd = 32'h0;
        n = 0;
        while (rd[1] !== 1'b1 && n < 300) begin bus(1'b0, `REG_STATUS_OFS, 8'h00, rd); n++; end
        if (n >= 300) begin bad_count++; give_verdict(); end
        `CHK(rd[0], 1'b0)
        bus(1'b0, `REG_CMD_OFS, 8'h00, rd);
        `CHK(rd, {24'h0, cmd})
        bus(1'b0, `REG_RESULT_OFS, 8'h00, rd);
        `CHK(din_mon[23:16], cmd)
    endtask

    task automatic run_conv(input logic [7:0] cmd, input logic [11:0] smp, input logic dbl);
        logic [31:0] rd;
        logic [11:0] res;
        @(posedge clk);
        sample_value <= smp;
        res = cmd[3] ? {4'h0, smp[11:4]} : smp;
        xfer(cmd, dbl, rd);
        `CHK(rd, {20'h0, res})
        `CHK(dout_mon[15:0], cmd[3] ? {1'b0, smp[11:4], 7'h0} : {1'b0, smp, 3'h0})
        `CHK({chan, res8, ref_sel, pd_sel}, cmd[6:0])
        `CHK(seen_hsw, ~cmd[2])
        `CHK(low_pwr, ~cmd[1])
        `CHK(seen_slp, 1'b0)
        `CHK({acq, s_hold, conv, sw_on}, 4'h0)
    endtask

    initial begin
        logic [31:0] rd;
        {clk, hsel, hwrite, pen_touched, sclk_q} = 5'h00;
        {haddr, hwdata, htrans, sample_value, din_mon, dout_mon} = '0;
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK({low_pwr, u_touch_link_if.dout_oe_n, u_touch_link_if.busy_oe_n}, 3'h7)
        bus(1'b0, 4'hc, 8'h00, rd);
        `CHK(rd, 32'h0)
        bus(1'b0, `REG_STATUS_OFS, 8'h00, rd);
        `CHK(rd, 32'h0)
        run_conv(8'h94, 12'ha5c, 1'b0);
        `CHK({seen_y, lr_sw}, 2'h3)
        pen_touched <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(irq, 1'b1)
        run_conv(8'hdb, 12'h3c7, 1'b1);
        `CHK({seen_x, irq}, 2'h2)
        run_conv(8'ha5, 12'hfff, 1'b0);
        `CHK({seen_aux, lr_sw, irq}, 3'h4)
        // A frame without a start bit must leave the device idle.
        xfer(8'h00, 1'b0, rd);
        `CHK({rd, seen_busy, low_pwr}, {32'h0, 2'h1})
        give_verdict();
    end
endmodule // touch_adc_serial_control_tb_top
